// >>> pst_pkg.sv
// constants and types for the power-on self-test sequencer
package pst_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int ROM_N = 4;
  localparam int KEY_N = 8;
  localparam int KEY_W = 3;
  localparam int LED_N = 8;
  // words walked per memory
  localparam logic [ADDR_W-1:0] BOOT_WORDS = 20'h0_0100;
  localparam logic [ADDR_W-1:0] RAM_WORDS = 20'h0_0400;
  localparam logic [ADDR_W-1:0] FLASH_WORDS = 20'h0_0400;
  // a good image sums to this value
  localparam logic [DATA_W-1:0] SUM_OK = 16'h0000;
  localparam logic [DATA_W-1:0] RAM_PATTERN = 16'hA5A5;
  // cycles without acknowledge before a bus is called dead
  localparam logic [7:0] BUS_TIMEOUT = 8'h40;
  localparam logic [31:0] SYNC_WAIT = 32'h0000_0003;
  // memory index display codes
  localparam logic [3:0] IDX_ZERO = 4'h0;
  localparam logic [3:0] IDX_BOOT = 4'h1;
  localparam logic [3:0] IDX_SYSRAM = 4'h2;
  localparam logic [3:0] IDX_DISPRAM = 4'h3;
  localparam logic [3:0] IDX_ACQRAM = 4'h4;
  localparam logic [3:0] IDX_FLASH = 4'h5;
  localparam logic [3:0] IDX_BLANK = 4'hF;
  // timing
  localparam int CLK_MHZ = 250;
  localparam int BLINK_MS = 250;
  localparam int LED_STEP_MS = 100;
  localparam int BLINK_CYCLES = BLINK_MS * 1000 * CLK_MHZ;
  localparam int LED_STEP_CYCLES = LED_STEP_MS * 1000 * CLK_MHZ;

  typedef enum logic [2:0] {
    MEM_BOOT = 3'h0,
    MEM_SYSRAM = 3'h1,
    MEM_DISPRAM = 3'h2,
    MEM_ACQRAM = 3'h3,
    MEM_FLASH = 3'h4
  } pst_mem_t;

  typedef enum logic [2:0] {
    MSG_NONE = 3'h0,
    MSG_PASS = 3'h1,
    MSG_ROM = 3'h2,
    MSG_RAM = 3'h3,
    MSG_KEY = 3'h4
  } pst_msg_t;

  typedef enum logic [14:0] {
    S_INIT = 15'h0001,
    S_BOOT_PLACE = 15'h0002,
    S_BOOT_SUM = 15'h0004,
    S_SYS_RAM = 15'h0008,
    S_DISP_RAM = 15'h0010,
    S_ACQ_RAM = 15'h0020,
    S_FLASH = 15'h0040,
    S_LED = 15'h0080,
    S_DISP_CHK = 15'h0100,
    S_KEYS = 15'h0200,
    S_KEY_WAIT = 15'h0400,
    S_PASS = 15'h0800,
    S_RUN = 15'h1000,
    S_FATAL = 15'h2000,
    S_HALT = 15'h4000
  } pst_state_t;
endpackage

// >>> pst_sequencer.sv
// power-on self-test sequencer top
`timescale 1ns/1ps
`default_nettype none
module pst_sequencer import pst_pkg::*; #(
  parameter int BLINK_CYC = BLINK_CYCLES,
  parameter int LED_CYC = LED_STEP_CYCLES
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic shiftKey,
  input wire logic [KEY_N-1:0] pushKey,
  output logic memReq,
  output logic memWe,
  output logic [2:0] memSel,
  output logic [ADDR_W-1:0] memAddr,
  output logic [DATA_W-1:0] memWdata,
  input wire logic memAck,
  input wire logic [DATA_W-1:0] memRdata,
  output logic [3:0] indexDigit,
  output logic [2:0] msgCode,
  output logic [3:0] msgRomBits,
  output logic [ADDR_W-1:0] msgRamAddr,
  output logic [DATA_W-1:0] msgRamBits,
  output logic [KEY_W-1:0] msgKey,
  output logic [LED_N-1:0] ledOn,
  output logic dispPattern,
  output logic loadInit,
  output logic halted
);

  typedef struct packed {
    pst_state_t st;
    logic ext;
    logic [ADDR_W-1:0] addr;
    logic [1:0] rom;
    logic wrPass;
    logic [DATA_W-1:0] sum;
    logic [7:0] busT;
    logic [31:0] tmr;
    logic blinkHi;
    logic [3:0] errIdx;
    logic memReq;
    logic memWe;
    pst_mem_t memSel;
    logic [ADDR_W-1:0] memAddr;
    logic [DATA_W-1:0] memWdata;
    logic [3:0] indexDigit;
    pst_msg_t msgCode;
    logic [3:0] msgRomBits;
    logic [ADDR_W-1:0] msgRamAddr;
    logic [DATA_W-1:0] msgRamBits;
    logic [KEY_W-1:0] msgKey;
    logic [LED_N-1:0] ledOn;
    logic dispPattern;
    logic loadInit;
    logic halted;
    logic [1:0] shS;
    logic shPrev;
    logic [KEY_N-1:0] k1;
    logic [KEY_N-1:0] k2;
  } pst_regs_t;

  pst_regs_t r;
  pst_regs_t next_r;

  logic ack;
  logic tout;
  logic lastWord;
  logic shiftPress;
  logic goFatal;
  logic [3:0] fatIdx;
  logic [ADDR_W-1:0] limit;
  logic [DATA_W-1:0] patWord;
  logic [DATA_W-1:0] newSum;

  // handshake and common decodes
  assign ack = r.memReq & memAck;
  assign tout = r.memReq & (r.busT == BUS_TIMEOUT);
  assign shiftPress = r.shS[1] & ~r.shPrev;
  assign patWord = r.addr[DATA_W-1:0] ^ RAM_PATTERN;
  assign newSum = r.sum + memRdata;
  assign lastWord = (r.addr == limit - 20'h0_0001);

  // word count of the memory now walked
  always_comb begin
    case (r.st)
      S_BOOT_PLACE: limit = 20'h0_0001;
      S_BOOT_SUM: limit = BOOT_WORDS;
      S_FLASH: limit = FLASH_WORDS;
      default: limit = RAM_WORDS;
    endcase
  end

  // next-state logic
  always_comb begin
    next_r = r;
    goFatal = 1'b0;
    fatIdx = IDX_ZERO;
    next_r.shS = {r.shS[0], shiftKey};
    next_r.shPrev = r.shS[1];
    next_r.k1 = pushKey;
    next_r.k2 = r.k1;
    next_r.loadInit = 1'b0;
    next_r.tmr = r.tmr + 32'h0000_0001;
    next_r.busT = (r.memReq && !memAck) ? r.busT + 8'h01 : 8'h00;
    // request issue: one word per request, dropped on acknowledge
    if (!r.memReq) begin
      next_r.memReq = r.st inside {S_BOOT_PLACE, S_BOOT_SUM, S_SYS_RAM,
                                   S_DISP_RAM, S_ACQ_RAM, S_FLASH};
    end else if (memAck) begin
      next_r.memReq = 1'b0;
    end
    next_r.memWe = r.wrPass;
    next_r.memWdata = patWord;
    next_r.memAddr = r.addr;
    case (r.st)
      S_INIT: begin
        next_r.memReq = 1'b0;
        if (r.tmr == SYNC_WAIT) begin
          next_r.ext = r.shS[1];
          next_r.st = S_BOOT_PLACE;
          next_r.memSel = MEM_BOOT;
          next_r.addr = '0;
          next_r.rom = 2'h0;
          next_r.wrPass = 1'b0;
        end
      end
      S_BOOT_PLACE: begin
        next_r.memAddr = {r.rom, 18'h0_0000};
        // id word of each socket names its position
        if (ack && memRdata != DATA_W'(r.rom)) begin
          goFatal = 1'b1;
          fatIdx = IDX_BOOT;
        end else if (ack) begin
          next_r.rom = r.rom + 2'h1;
          if (r.rom == 2'(ROM_N - 1)) begin
            next_r.st = S_BOOT_SUM;
            next_r.sum = '0;
          end
        end
        if (tout) begin
          goFatal = 1'b1;
          fatIdx = IDX_BOOT;
        end
      end
      S_BOOT_SUM: begin
        next_r.memAddr = {r.rom, r.addr[ADDR_W-3:0]};
        if (ack) begin
          next_r.sum = newSum;
          next_r.addr = r.addr + 20'h0_0001;
          if (lastWord) begin
            next_r.addr = '0;
            next_r.sum = '0;
            next_r.rom = r.rom + 2'h1;
            if (newSum != SUM_OK) begin
              next_r.msgRomBits[r.rom] = 1'b1;
            end
            if (r.rom == 2'(ROM_N - 1)) begin
              if (newSum != SUM_OK || r.msgRomBits != 4'h0) begin
                next_r.msgCode = MSG_ROM;
                next_r.st = S_HALT;
              end else begin
                next_r.st = S_SYS_RAM;
                next_r.memSel = MEM_SYSRAM;
                next_r.wrPass = 1'b1;
              end
            end
          end
        end
        if (tout) begin
          goFatal = 1'b1;
          fatIdx = IDX_BOOT;
        end
      end
      S_SYS_RAM, S_DISP_RAM, S_ACQ_RAM: begin
        if (ack) begin
          next_r.addr = r.addr + 20'h0_0001;
          if (!r.wrPass && memRdata != patWord) begin
            if (r.st == S_SYS_RAM) begin
              next_r.msgCode = MSG_RAM;
              next_r.msgRamAddr = r.addr;
              next_r.msgRamBits = memRdata ^ patWord;
              next_r.st = S_HALT;
            end else begin
              goFatal = 1'b1;
              fatIdx = (r.st == S_DISP_RAM) ? IDX_DISPRAM : IDX_ACQRAM;
            end
          end else if (lastWord) begin
            next_r.addr = '0;
            next_r.wrPass = ~r.wrPass;
            if (!r.wrPass) begin
              next_r.wrPass = 1'b1;
              case (r.st)
                S_SYS_RAM: begin
                  next_r.st = S_DISP_RAM;
                  next_r.memSel = MEM_DISPRAM;
                end
                S_DISP_RAM: begin
                  next_r.st = S_ACQ_RAM;
                  next_r.memSel = MEM_ACQRAM;
                end
                default: begin
                  next_r.st = S_FLASH;
                  next_r.memSel = MEM_FLASH;
                  next_r.wrPass = 1'b0;
                  next_r.sum = '0;
                end
              endcase
            end
          end
        end
        if (tout) begin
          goFatal = 1'b1;
          case (r.st)
            S_SYS_RAM: fatIdx = IDX_SYSRAM;
            S_DISP_RAM: fatIdx = IDX_DISPRAM;
            default: fatIdx = IDX_ACQRAM;
          endcase
        end
      end
      S_FLASH: begin
        if (ack) begin
          next_r.sum = newSum;
          next_r.addr = r.addr + 20'h0_0001;
          if (lastWord) begin
            if (newSum != SUM_OK) begin
              goFatal = 1'b1;
              fatIdx = IDX_FLASH;
            end else if (r.ext) begin
              next_r.st = S_LED;
              next_r.ledOn = {{(LED_N-1){1'b0}}, 1'b1};
              next_r.tmr = '0;
            end else begin
              next_r.st = S_KEYS;
            end
          end
        end
        if (tout) begin
          goFatal = 1'b1;
          fatIdx = IDX_FLASH;
        end
      end
      S_LED: begin
        // one indicator at a time, walked upward
        if (shiftPress) begin
          next_r.ledOn = '0;
          next_r.st = S_KEYS;
        end else if (r.tmr == 32'(LED_CYC - 1)) begin
          next_r.tmr = '0;
          next_r.ledOn = r.ledOn << 1;
          if (r.ledOn[LED_N-1]) begin
            next_r.st = S_DISP_CHK;
            next_r.dispPattern = 1'b1;
          end
        end
      end
      S_DISP_CHK: begin
        if (shiftPress) begin
          next_r.dispPattern = 1'b0;
          next_r.st = S_KEYS;
        end
      end
      S_KEYS: begin
        // a key already pressed here is stuck; shift is not among them
        if (r.k2 != '0) begin
          for (int i = KEY_N - 1; i >= 0; i--) begin
            if (r.k2[i]) begin
              next_r.msgKey = KEY_W'(i);
            end
          end
          next_r.msgCode = MSG_KEY;
          next_r.st = S_KEY_WAIT;
        end else begin
          next_r.st = S_PASS;
        end
      end
      S_KEY_WAIT: begin
        if (shiftPress) begin
          next_r.st = S_PASS;
        end
      end
      S_PASS: begin
        next_r.msgCode = MSG_PASS;
        next_r.loadInit = 1'b1;
        next_r.st = S_RUN;
      end
      S_RUN: begin
        next_r.st = S_RUN;
      end
      S_FATAL: begin
        // alternate zero and the code forever
        next_r.halted = 1'b1;
        if (r.tmr == 32'(BLINK_CYC - 1)) begin
          next_r.tmr = '0;
          next_r.blinkHi = ~r.blinkHi;
          next_r.indexDigit = r.blinkHi ? IDX_ZERO : r.errIdx;
        end
      end
      S_HALT: begin
        next_r.memReq = 1'b0;
        next_r.halted = 1'b1;
      end
      default: begin
        next_r.st = S_HALT;
      end
    endcase
    if (goFatal) begin
      next_r.st = S_FATAL;
      next_r.errIdx = fatIdx;
      next_r.indexDigit = IDX_ZERO;
      next_r.blinkHi = 1'b0;
      next_r.memReq = 1'b0;
      next_r.tmr = '0;
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      r <= '0;
      r.st <= S_INIT;
      r.memSel <= MEM_BOOT;
      r.msgCode <= MSG_NONE;
      r.indexDigit <= IDX_BLANK;
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from the state flops
  assign memReq = r.memReq;
  assign memWe = r.memWe;
  assign memSel = r.memSel;
  assign memAddr = r.memAddr;
  assign memWdata = r.memWdata;
  assign indexDigit = r.indexDigit;
  assign msgCode = r.msgCode;
  assign msgRomBits = r.msgRomBits;
  assign msgRamAddr = r.msgRamAddr;
  assign msgRamBits = r.msgRamBits;
  assign msgKey = r.msgKey;
  assign ledOn = r.ledOn;
  assign dispPattern = r.dispPattern;
  assign loadInit = r.loadInit;
  assign halted = r.halted;

endmodule
`default_nettype wire

// >>> pst_sequencer_monitor.sv
// port checker for the self-test sequencer, bound to its top
`timescale 1ns/1ps
`default_nettype none
module pst_sequencer_monitor import pst_pkg::*; #(
  parameter int BLINK_CYC = 8
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic memReq,
  input wire logic memWe,
  input wire logic [2:0] memSel,
  input wire logic [ADDR_W-1:0] memAddr,
  input wire logic [DATA_W-1:0] memWdata,
  input wire logic memAck,
  input wire logic [3:0] indexDigit,
  input wire logic [2:0] msgCode,
  input wire logic [3:0] msgRomBits,
  input wire logic [LED_N-1:0] ledOn,
  input wire logic dispPattern,
  input wire logic loadInit,
  input wire logic halted
);
  logic [2:0] maxSel;
  logic [7:0] waitCnt;
  logic [31:0] holdCnt;
  logic [3:0] prevDigit;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // last memory reached, ack wait, cycles since digit change
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      maxSel <= 3'h0;
      waitCnt <= 8'h00;
      holdCnt <= 32'h0000_0000;
    end else begin
      if (memReq)
        maxSel <= memSel;
      waitCnt <= (memReq && !memAck) ? waitCnt + 8'h01 : 8'h00;
      holdCnt <= (indexDigit != prevDigit) ? 32'h0000_0000
                                           : holdCnt + 32'h0000_0001;
    end
    prevDigit <= indexDigit;
  end
  a_req_hold:
    assert property (memReq && !memAck && waitCnt < 8'h3c |=>
      memReq && $stable(memAddr) && $stable(memSel) && $stable(memWe))
    else $error("memory request changed before acknowledge");
  a_req_gap:
    assert property (memReq && memAck |=> !memReq)
    else $error("no idle cycle after acknowledge");
  a_write_data:
    assert property (memReq && memWe |->
      memWdata == (memAddr[DATA_W-1:0] ^ RAM_PATTERN))
    else $error("write data not the address pattern");
  a_rom_readonly:
    assert property (memReq && (memSel == MEM_BOOT || memSel == MEM_FLASH)
      |-> !memWe)
    else $error("write to a read-only memory");
  a_test_order:
    assert property (memReq |-> memSel >= maxSel)
    else $error("memory test order went backwards");
  a_halt_holds:
    assert property (halted |=> halted && !memReq && !loadInit)
    else $error("sequence moved on after halt");
  a_blink_pair:
    assert property (halted && $changed(indexDigit) |->
      indexDigit == IDX_ZERO || $past(indexDigit) == IDX_ZERO)
    else $error("blink does not alternate with zero");
  a_blink_rate:
    assert property (halted && indexDigit != IDX_BLANK |->
      holdCnt <= BLINK_CYC)
    else $error("blink digit held too long");
  a_led_onehot:
    assert property (ledOn != '0 |-> $onehot(ledOn))
    else $error("more than one LED lit");
  a_load_pulse:
    assert property (loadInit |-> (msgCode == MSG_PASS) ##1 !loadInit)
    else $error("settings load without pass message");
  a_disp_quiet:
    assert property (dispPattern |-> ledOn == '0 && !memReq)
    else $error("pattern shown while other steps run");
  a_rom_flags:
    assert property (msgCode == MSG_ROM |-> msgRomBits != 4'h0)
    else $error("ROM message without failing ROM");
  c_pass: cover property (loadInit);
  c_blink: cover property (halted && indexDigit == IDX_SYSRAM);
  c_pattern: cover property (dispPattern);
endmodule
bind pst_sequencer pst_sequencer_monitor #(.BLINK_CYC(BLINK_CYC)) mon (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .memReq(memReq), .memWe(memWe),
  .memSel(memSel), .memAddr(memAddr), .memWdata(memWdata),
  .memAck(memAck), .indexDigit(indexDigit), .msgCode(msgCode),
  .msgRomBits(msgRomBits), .ledOn(ledOn), .dispPattern(dispPattern),
  .loadInit(loadInit), .halted(halted)
);
`default_nettype wire

// >>> pst_mem_model.sv
// memories behind the sequencer: boot ROMs, RAMs and flash
`timescale 1ns/1ps
`default_nettype none
module pst_mem_model import pst_pkg::*; (
  input wire logic ref_clk,
  input wire logic memReq,
  input wire logic memWe,
  input wire logic [2:0] memSel,
  input wire logic [ADDR_W-1:0] memAddr,
  input wire logic [DATA_W-1:0] memWdata,
  output logic memAck,
  output logic [DATA_W-1:0] memRdata
);
  logic misplace = 1'b0;
  logic [3:0] romBad = 4'h0;
  logic [2:0] deadSel = 3'h7;
  logic [2:0] flipSel = 3'h7;
  logic [9:0] flipAddr = 10'h000;
  logic [DATA_W-1:0] flipMask = 16'h0000;
  logic [1:0] ackDly = 2'h0;
  logic [1:0] waitCnt = 2'h0;
  logic [1:0] romIdx;
  logic romErr;
  logic [DATA_W-1:0] ram [0:4095];
  logic [DATA_W-1:0] word;
  // words pair up so an image sums to zero; word 0 holds the seed
  function automatic logic [DATA_W-1:0] img(
    input logic [DATA_W-1:0] seed, input logic [9:0] a);
    logic [DATA_W-1:0] b;
    b = seed ^ {6'h00, a[9:1], 1'b0};
    return a[0] ? -b : b;
  endfunction
  // misplace swaps sockets 2 and 3; a bad ROM skews every word but 0
  assign romIdx = memAddr[19:18] ^ {1'b0, misplace & memAddr[19]};
  assign romErr = romBad[memAddr[19:18]] && memAddr[7:0] != 8'h00;
  always_comb begin
    case (memSel)
      3'h0: word = img({14'h0000, romIdx}, memAddr[9:0]) + 16'(romErr);
      3'h4: word = img(16'h3c3c, memAddr[9:0]);
      default: word = ram[{memSel[1:0], memAddr[9:0]}] ^
        ((memSel == flipSel && memAddr[9:0] == flipAddr) ? flipMask : '0);
    endcase
  end
  initial memAck = 1'b0;
  initial memRdata = 16'h0000;
  // answer after ackDly cycles, never for deadSel; idle data toggles
  always @(posedge ref_clk) begin
    memAck <= 1'b0;
    memRdata <= ~memRdata;
    if (memReq && !memAck && memSel != deadSel) begin
      waitCnt <= waitCnt + 2'h1;
      if (waitCnt == ackDly) begin
        waitCnt <= 2'h0;
        memAck <= 1'b1;
        memRdata <= word;
        if (memWe)
          ram[{memSel[1:0], memAddr[9:0]}] <= memWdata;
      end
    end
  end
endmodule
`default_nettype wire

// >>> pst_sequencer_tb_top.sv
// self-checking bench for the self-test sequencer
`timescale 1ns/1ps
`default_nettype none
module pst_sequencer_tb_top import pst_pkg::*;;
  localparam int BLINK = 8;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic shiftKey = 1'b0;
  logic [KEY_N-1:0] pushKey = '0;
  logic memReq, memWe, memAck, dispPattern, loadInit, halted;
  logic [2:0] memSel, msgCode, lastSel;
  logic [ADDR_W-1:0] memAddr, msgRamAddr;
  logic [DATA_W-1:0] memWdata, memRdata, msgRamBits;
  logic [3:0] indexDigit, msgRomBits;
  logic [KEY_W-1:0] msgKey;
  logic [LED_N-1:0] ledOn, ledSeen;
  logic [14:0] selTrail;
  logic [31:0] lfsr = 32'h0000_6b7e;
  int loadCnt, mismatches = 0, compares = 0;
  always #2 ref_clk = ~ref_clk;
  pst_sequencer #(.BLINK_CYC(BLINK), .LED_CYC(4)) dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .shiftKey(shiftKey),
    .pushKey(pushKey), .memReq(memReq), .memWe(memWe), .memSel(memSel),
    .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck),
    .memRdata(memRdata), .indexDigit(indexDigit), .msgCode(msgCode),
    .msgRomBits(msgRomBits), .msgRamAddr(msgRamAddr),
    .msgRamBits(msgRamBits), .msgKey(msgKey), .ledOn(ledOn),
    .dispPattern(dispPattern), .loadInit(loadInit), .halted(halted));
  pst_mem_model mdl (
    .ref_clk(ref_clk), .memReq(memReq), .memWe(memWe), .memSel(memSel),
    .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck),
    .memRdata(memRdata));
  // memories visited, LEDs lit and load pulses in each run
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      selTrail <= '0;
      lastSel <= 3'h7;
      ledSeen <= '0;
      loadCnt <= 0;
    end else begin
      if (memReq && memSel != lastSel) begin
        selTrail <= {selTrail[11:0], memSel};
        lastSel <= memSel;
      end
      ledSeen <= ledSeen | ledOn;
      loadCnt <= loadCnt + int'(loadInit);
    end
  end
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [KEY_W-1:0] lowKey(input logic [KEY_N-1:0] k);
    lowKey = '0;
    for (int i = KEY_N - 1; i >= 0; i--)
      if (k[i]) lowKey = KEY_W'(i);
  endfunction
  function automatic logic hit(input int k);
    case (k)
      0: return halted;
      1: return msgCode == MSG_PASS;
      2: return dispPattern;
      3: return msgCode == MSG_KEY;
      default: return ledOn != '0;
    endcase
  endfunction
  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_blink(input logic [3:0] code);
    logic [15:0] seen;
    seen = '0;
    repeat (5 * BLINK) begin
      tick;
      seen = seen | (16'h0001 << indexDigit);
    end
    chk("blink", (16'h0001 << code) | 16'h0001, seen);
  endtask
  task automatic wait_for(input int k, input int lim);
    int n;
    n = 0;
    while (hit(k) !== 1'b1 && n < lim) begin
      tick;
      n++;
    end
    chk("reached", 32'h1, hit(k));
  endtask
  task automatic boot(input logic held);
    tick;
    sys_rst = 1'b1;
    shiftKey = held;
    repeat (8) tick;
    sys_rst = 1'b0;
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard, a little above the length of the whole test sequence
  initial begin
    repeat (104000) @(posedge ref_clk);
    mismatches++;
    wrap_up;
  end
  // test sequence
  initial begin
    mdl.misplace = 1'b1;
    boot(1'b0);
    wait_for(0, 2000);
    chk_blink(IDX_BOOT);
    chk("sel", 32'h0, lastSel);
    $display("end of placement test");
    lfsr = nxt(lfsr);
    mdl.misplace = 1'b0;
    mdl.romBad = lfsr[3:0] | 4'h2;
    mdl.ackDly = lfsr[5:4];
    boot(1'b0);
    wait_for(0, 20000);
    chk("msg", MSG_ROM, msgCode);
    chk("rombits", mdl.romBad, msgRomBits);
    chk("sel", 32'h0, lastSel);
    $display("end of checksum test");
    lfsr = nxt(lfsr);
    mdl.romBad = 4'h0;
    mdl.ackDly = 2'h0;
    mdl.flipSel = MEM_SYSRAM;
    mdl.flipAddr = lfsr[9:0];
    mdl.flipMask = lfsr[31:16] | 16'h0100;
    boot(1'b0);
    wait_for(0, 20000);
    chk("msg", MSG_RAM, msgCode);
    chk("ramaddr", mdl.flipAddr, msgRamAddr);
    chk("rambits", mdl.flipMask, msgRamBits);
    chk("sel", 32'h1, lastSel);
    $display("end of ram word test");
    mdl.flipSel = 3'h7;
    mdl.deadSel = MEM_SYSRAM;
    boot(1'b0);
    wait_for(0, 10000);
    chk_blink(IDX_SYSRAM);
    $display("end of ram bus test");
    // dead display RAM, then dead flash
    mdl.deadSel = MEM_DISPRAM;
    boot(1'b0);
    wait_for(0, 12000);
    chk_blink(IDX_DISPRAM);
    chk("sel", 32'h2, lastSel);
    $display("end of display ram test");
    mdl.deadSel = MEM_FLASH;
    boot(1'b0);
    wait_for(0, 25000);
    chk_blink(IDX_FLASH);
    chk("sel", 32'h4, lastSel);
    $display("end of flash test");
    mdl.deadSel = 3'h7;
    boot(1'b0);
    wait_for(1, 40000);
    repeat (4) tick;
    chk("order", {3'h0, 3'h1, 3'h2, 3'h3, 3'h4}, selTrail);
    chk("load", 32'h1, loadCnt);
    chk("extras", 32'h0, {dispPattern, ledSeen});
    $display("end of normal test");
    lfsr = nxt(lfsr);
    pushKey = lfsr[7:0] | 8'h80;
    boot(1'b1);
    repeat (20) tick;
    shiftKey = 1'b0;
    wait_for(4, 40000);
    wait_for(2, 200);
    chk("leds", {LED_N{1'b1}}, ledSeen);
    chk("order", {3'h0, 3'h1, 3'h2, 3'h3, 3'h4}, selTrail);
    shiftKey = 1'b1;
    wait_for(3, 100);
    chk("pattern", 32'h0, dispPattern);
    chk("key", lowKey(pushKey), msgKey);
    chk("load", 32'h0, loadCnt);
    shiftKey = 1'b0;
    repeat (8) tick;
    shiftKey = 1'b1;
    wait_for(1, 100);
    repeat (4) tick;
    chk("load", 32'h1, loadCnt);
    $display("end of extended test");
    wrap_up;
  end
endmodule
`default_nettype wire
